// [src/sfr_map.svh]
`ifndef SFR_MAP_SVH
`define SFR_MAP_SVH

// Register offsets
`define SFR_REG_SLOT    8'h00
`define SFR_REG_LOGCTL  8'h47
`define SFR_REG_RECOV   8'h4f
`define SFR_REG_SWEN    8'h50
`define SFR_REG_STAT    8'h51

// Reset values
`define SFR_SLOT_RST    8'hf0
`define SFR_LOGCTL_RST  8'h00
`define SFR_RECOV_RST   8'h00
`define SFR_SWEN_RST    8'h01

// Field positions and codes
`define SFR_MODE_BIT    3
`define SFR_LOG_NONE    2'b11

// Clock rate and autoretry delays in microseconds
`define SFR_CLK_MHZ     100
`define SFR_DLY0_US     20
`define SFR_DLY1_US     18750
`define SFR_DLY2_US     37500
`define SFR_DLY3_US     75000
`define SFR_DLY4_US     150000
`define SFR_DLY5_US     300000
`define SFR_DLY6_US     600000
`define SFR_DLY7_US     2400000

`endif

// [src/sfr_pkg.sv]
package sfr_pkg;
   typedef enum logic [2:0] {
      SFR_RUN   = 3'b001,
      SFR_RETRY = 3'b010,
      SFR_LATCH = 3'b100
   } sfr_state_t;
endpackage

// [src/sfr_delay_timer.sv]
`timescale 1ns/1ns
module sfr_delay_timer #(
   parameter int W = 32
) (
   input  wire logic         mclk_in,
   input  wire logic         rst_in,
   input  wire logic         start_in,
   input  wire logic [W-1:0] len_in,
   output logic              done_out,
   output logic [W-1:0]      count_out
);
   logic         run;
   logic [W-1:0] cnt;
   logic [W-1:0] len;

   // Done once the loaded length has elapsed
   assign done_out  = run && (cnt == len) && !start_in;
   assign count_out = cnt;

   // Cycle counter, restarted by each start
   always_ff @(posedge mclk_in) begin
      if (rst_in || start_in) begin
         run <= start_in;
         cnt <= {{(W-1){1'b0}}, 1'b1};
         len <= start_in ? len_in : {W{1'b0}};
      end else if (done_out) begin
         run <= 1'b0;
      end else if (run) begin
         cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule

// [src/sfr_ctrl.sv]
`timescale 1ns/1ns
`include "sfr_map.svh"
// Notes on behaviour
// - Any OV/UV fault while sequencing drops every enable, ignoring critical enables.
// - Sequencing fault logs failing slot into record low nibble unless logging off.
// - Tracking fault starts a log unless logging off, clearing each failed channel bit to 0.
// - Recovery bit 0: shut down on critical fault, restart after retry delay.
// - Retry delay comes from three-bit field, 20 us up to 2.4 s.
// - Recovery bit 1: critical fault drops all enables and keeps them low.
// - Latch-off restarts only after enable pin toggles or software enable clears.
// - Log setting: 00 lines and results, 01 lines, 10 results, 11 nothing; here 00, 01 and 10 all log the whole record.
module sfr_ctrl import sfr_pkg::*; #(
   parameter int          NCH  = 12,
   parameter int          NTRK = 4,
   // Retry lengths in cycles, entry n serves delay code n
   parameter logic [7:0][31:0] RETRY_CYC = {
      32'(`SFR_DLY7_US * `SFR_CLK_MHZ), 32'(`SFR_DLY6_US * `SFR_CLK_MHZ),
      32'(`SFR_DLY5_US * `SFR_CLK_MHZ), 32'(`SFR_DLY4_US * `SFR_CLK_MHZ),
      32'(`SFR_DLY3_US * `SFR_CLK_MHZ), 32'(`SFR_DLY2_US * `SFR_CLK_MHZ),
      32'(`SFR_DLY1_US * `SFR_CLK_MHZ), 32'(`SFR_DLY0_US * `SFR_CLK_MHZ)
   }
) (
   input  wire logic            mclk_in,
   input  wire logic            rst_in,
   input  wire logic            en_in,
   input  wire logic [NCH-1:0]  ov_fault_in,
   input  wire logic [NCH-1:0]  uv_fault_in,
   input  wire logic            crit_fault_in,
   input  wire logic            seq_active_in,
   input  wire logic [3:0]      seq_slot_in,
   input  wire logic [NTRK-1:0] track_fault_in,
   input  wire logic            nv_done_in,
   input  wire logic [7:0]      reg_addr_in,
   input  wire logic            reg_wr_in,
   input  wire logic [7:0]      reg_wdata_in,
   output logic [7:0]           reg_rdata_out,
   output logic                 supply_en_gate_out,
   output logic                 restart_out,
   output logic                 store_busy_out,
   output logic                 nv_wr_req_out,
   output logic [7:0]           nv_addr_out,
   output logic [7:0]           nv_data_out
);
   sfr_state_t  st;
   sfr_state_t  next_st;
   logic [7:0]  slot_record;
   logic [7:0]  log_ctl;
   logic [7:0]  recov_cfg;
   logic [7:0]  sw_en;
   logic [1:0]  en_sync;
   logic        enabled_q;
   logic        latch_armed;
   logic        store_busy;
   logic [7:0]  nv_data;
   logic        restart;
   logic [31:0] retry_len;
   logic        retry_done;
   logic [31:0] retry_cnt;

   wire enabled   = en_sync[1] & sw_en[0];
   wire in_run    = (st == SFR_RUN) && enabled;
   wire seq_fault = seq_active_in && |(ov_fault_in | uv_fault_in);
   wire trk_fault = |track_fault_in;
   wire fault_evt = in_run && (seq_fault || crit_fault_in || trk_fault);
   wire log_on    = log_ctl[1:0] != `SFR_LOG_NONE;
   wire log_start = fault_evt && log_on;
   wire latch_mode = recov_cfg[`SFR_MODE_BIT];
   wire latch_free = (st == SFR_LATCH) && latch_armed && enabled;
   wire wr_log    = reg_wr_in && reg_addr_in == `SFR_REG_LOGCTL;
   wire wr_recov  = reg_wr_in && reg_addr_in == `SFR_REG_RECOV;
   wire wr_swen   = reg_wr_in && reg_addr_in == `SFR_REG_SWEN;

   // Record update: failed tracking bits cleared, slot on sequencing fault
   wire [3:0] next_trk  = slot_record[7:4] & ~track_fault_in[3:0];
   wire [3:0] next_slot = seq_fault ? seq_slot_in : slot_record[3:0];
   wire [7:0] next_rec  = {next_trk, next_slot};

   // Delay selection table
   assign retry_len  = RETRY_CYC[recov_cfg[2:0]];

   // Outputs
   assign supply_en_gate_out = in_run;
   assign restart_out    = restart;
   assign store_busy_out = store_busy;
   assign nv_wr_req_out  = store_busy;
   assign nv_addr_out    = `SFR_REG_SLOT;
   assign nv_data_out    = nv_data;

   sfr_delay_timer #(
      .W (32)
   ) u_retry (
      .mclk_in   (mclk_in),
      .rst_in    (rst_in),
      .start_in  (fault_evt && !latch_mode),
      .len_in    (retry_len),
      .done_out  (retry_done),
      .count_out (retry_cnt)
   );

   // Recovery state selection
   always_comb begin
      next_st = st;
      case (st)
         SFR_RUN: begin
            if (fault_evt) begin
               next_st = latch_mode ? SFR_LATCH : SFR_RETRY;
            end
         end
         SFR_RETRY: begin
            if (retry_done) begin
               next_st = SFR_RUN;
            end
         end
         SFR_LATCH: begin
            if (latch_free) begin
               next_st = SFR_RUN;
            end
         end
         default: next_st = SFR_RUN;
      endcase
   end

   // Enable pin synchroniser and state
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         en_sync   <= 2'b00;
         enabled_q <= 1'b0;
         st        <= SFR_RUN;
         restart   <= 1'b0;
      end else begin
         en_sync   <= {en_sync[0], en_in};
         enabled_q <= enabled;
         st        <= next_st;
         restart   <= (st == SFR_RETRY && retry_done) || latch_free
                      || (st == SFR_RUN && enabled && !enabled_q);
      end
   end

   // Latch release needs enable low or software enable cleared first
   always_ff @(posedge mclk_in) begin
      if (rst_in || st != SFR_LATCH) begin
         latch_armed <= 1'b0;
      end else if (!enabled) begin
         latch_armed <= 1'b1;
      end
   end

   // Fault record and nonvolatile store, start wins over completion
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         slot_record <= `SFR_SLOT_RST;
         nv_data     <= `SFR_SLOT_RST;
         store_busy  <= 1'b0;
      end else if (log_start) begin
         slot_record <= next_rec;
         nv_data     <= next_rec;
         store_busy  <= 1'b1;
      end else if (nv_done_in) begin
         store_busy  <= 1'b0;
      end
   end

   // Software registers
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         log_ctl   <= `SFR_LOGCTL_RST;
         recov_cfg <= `SFR_RECOV_RST;
         sw_en     <= `SFR_SWEN_RST;
      end else begin
         log_ctl   <= wr_log ? reg_wdata_in : log_ctl;
         recov_cfg <= wr_recov ? reg_wdata_in : recov_cfg;
         sw_en     <= wr_swen ? {7'h00, reg_wdata_in[0]} : sw_en;
      end
   end

   // Read data, registered, unmapped reads zero
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         reg_rdata_out <= 8'h00;
      end else begin
         case (reg_addr_in)
            `SFR_REG_SLOT:   reg_rdata_out <= slot_record;
            `SFR_REG_LOGCTL: reg_rdata_out <= log_ctl;
            `SFR_REG_RECOV:  reg_rdata_out <= recov_cfg;
            `SFR_REG_SWEN:   reg_rdata_out <= sw_en;
            `SFR_REG_STAT:   reg_rdata_out <= {4'h0, latch_armed, st == SFR_LATCH,
                                               st == SFR_RETRY, store_busy};
            default:         reg_rdata_out <= 8'h00;
         endcase
      end
   end

   // Checks
   property p_seq_off;
      @(posedge mclk_in) disable iff (rst_in)
      (in_run && seq_fault) |=> !supply_en_gate_out;
   endproperty
   a_seq_off: assert property (p_seq_off) else $error("enable kept on seq fault");

   property p_slot_log;
      @(posedge mclk_in) disable iff (rst_in)
      (in_run && seq_fault && log_on) |=> slot_record[3:0] == $past(seq_slot_in);
   endproperty
   a_slot_log: assert property (p_slot_log) else $error("slot not logged");

   property p_trk_log;
      @(posedge mclk_in) disable iff (rst_in)
      (in_run && trk_fault && log_on) |=> store_busy
         && (slot_record[7:4] & $past(track_fault_in[3:0])) == 4'h0;
   endproperty
   a_trk_log: assert property (p_trk_log) else $error("tracking log wrong");

   property p_no_log;
      @(posedge mclk_in) disable iff (rst_in)
      (fault_evt && !log_on && !store_busy) |=> !store_busy && $stable(slot_record);
   endproperty
   a_no_log: assert property (p_no_log) else $error("logged when off");

   property p_retry_go;
      @(posedge mclk_in) disable iff (rst_in)
      (fault_evt && !latch_mode) |=> st == SFR_RETRY ##0 !supply_en_gate_out;
   endproperty
   a_retry_go: assert property (p_retry_go) else $error("no autoretry");

   property p_retry_len;
      @(posedge mclk_in) disable iff (rst_in)
      (st == SFR_RETRY && retry_done) |-> retry_cnt == retry_len ##1 restart_out;
   endproperty
   a_retry_len: assert property (p_retry_len) else $error("retry delay wrong");

   property p_latch_off;
      @(posedge mclk_in) disable iff (rst_in)
      (fault_evt && latch_mode) |=> (st == SFR_LATCH && !supply_en_gate_out)[*2];
   endproperty
   a_latch_off: assert property (p_latch_off) else $error("latch not held");

   property p_latch_hold;
      @(posedge mclk_in) disable iff (rst_in)
      (st == SFR_LATCH && !latch_armed && enabled) |=> st == SFR_LATCH;
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch left early");

   property p_busy_hold;
      @(posedge mclk_in) disable iff (rst_in)
      (store_busy && !nv_done_in) |=> store_busy;
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

   c_retry:  cover property (@(posedge mclk_in) st == SFR_RETRY ##1 st == SFR_RUN);
   c_latch:  cover property (@(posedge mclk_in) latch_free);
   c_stored: cover property (@(posedge mclk_in) store_busy ##1 !store_busy);
endmodule

// [testbench/sfr_store_model.sv]
`timescale 1ns/1ns
// Fault-store writer on the far side of the nonvolatile request
module sfr_store_model (
   input  wire logic       mclk_in,
   input  wire logic       rst_in,
   input  wire logic       nv_wr_req_in,
   input  wire logic [7:0] nv_data_in,
   input  wire logic [7:0] dly_in,
   output logic            nv_done_out,
   output logic [7:0]      stored_out
);
   logic [7:0] cnt;

   // Write completes dly_in cycles after the request is seen
   always_ff @(posedge mclk_in) begin
      if (rst_in || !nv_wr_req_in) begin
         cnt         <= 8'h00;
         nv_done_out <= 1'b0;
      end else begin
         cnt         <= cnt + 8'h01;
         nv_done_out <= (cnt == dly_in);
         if (cnt == dly_in) begin
            stored_out <= nv_data_in; // Captured at completion
         end
      end
   end
endmodule

// [testbench/sfr_ctrl_tb_top.sv]
`timescale 1ns/1ns
module sfr_ctrl_tb_top;
   logic        mclk_in;
   logic        rst_in = 1'b1;
   logic        en_in = 1'b1;
   logic        crit = 1'b0;
   logic        seq_act = 1'b0;
   logic        reg_wr = 1'b0;
   logic        gate, restart, busy, nv_req, nv_done;
   logic [11:0] ov = 12'h000;
   logic [11:0] uv = 12'h000;
   logic [3:0]  slot = 4'h0;
   logic [3:0]  trk = 4'h0;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic [7:0]  dly = 8'h03;
   logic [7:0]  rec = 8'hf0;
   logic [7:0]  rdata, nv_addr, nv_data, stored;
   int          bad_count = 0;
   int          tests_run = 0;
   int          cyc = 0;
   int          k;

   // Short retry lengths keep the run brief
   sfr_ctrl #(
      .RETRY_CYC({32'd24, 32'd22, 32'd20, 32'd18, 32'd16, 32'd14, 32'd12, 32'd10})
   ) dut (
      .mclk_in(mclk_in), .rst_in(rst_in), .en_in(en_in), .ov_fault_in(ov), .uv_fault_in(uv),
      .crit_fault_in(crit), .seq_active_in(seq_act), .seq_slot_in(slot), .track_fault_in(trk),
      .nv_done_in(nv_done), .reg_addr_in(addr), .reg_wr_in(reg_wr), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .supply_en_gate_out(gate), .restart_out(restart),
      .store_busy_out(busy), .nv_wr_req_out(nv_req), .nv_addr_out(nv_addr), .nv_data_out(nv_data)
   );

   sfr_store_model model (
      .mclk_in(mclk_in), .rst_in(rst_in), .nv_wr_req_in(nv_req), .nv_data_in(nv_data),
      .dly_in(dly), .nv_done_out(nv_done), .stored_out(stored)
   );

   // Clock and hang guard
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         summarize();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge mclk_in);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      tick(1); // Strobe low a full cycle between writes
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      addr = a;
      tick(1);
      chk(rdata, exp);
   endtask
   task automatic waitr(input int lim);
      k = 1;
      while (restart !== 1'b1 && k < lim) begin
         tick(1);
         k++;
      end
   endtask
   task automatic hit_crit();
      crit = 1'b1;
      tick(1);
      crit = 1'b0;
   endtask

   // Reset values, read-only record, unmapped read
   task automatic t_regs();
      rdchk(8'h00, 8'hf0);
      rdchk(8'h47, 8'h00);
      rdchk(8'h4f, 8'h00);
      rdchk(8'h50, 8'h01);
      rdchk(8'h33, 8'h00);
      wr(8'h00, 8'h55);
      rdchk(8'h00, 8'hf0);
      wr(8'h4f, 8'ha5);
      rdchk(8'h4f, 8'ha5);
      wr(8'h4f, 8'h00);
      chk(nv_addr, 8'h00);
      $display("regs done");
   endtask

   // Sequencing faults under every log setting, with autoretry
   task automatic t_log();
      for (int c = 0; c < 4; c++) begin
         wr(8'h47, c[7:0]);
         slot = 4'h3 + c[3:0];
         seq_act = 1'b1;
         ov = c[0] ? 12'h000 : (12'h001 << c);
         uv = c[0] ? (12'h001 << c) : 12'h000;
         tick(1);
         seq_act = 1'b0;
         ov = 12'h000;
         uv = 12'h000;
         if (c != 3) rec = {rec[7:4], slot};
         chk(gate, 1'b0);
         chk(busy, c != 3);
         waitr(100);
         chk(k, 11);
         chk(gate, 1'b1);
         rdchk(8'h00, rec);
         if (c != 3) chk(stored, rec);
      end
      $display("log done");
   endtask

   // Tracking fault clears the failed channel bits
   task automatic t_trk();
      wr(8'h47, 8'h01);
      trk = 4'b0101;
      tick(1);
      trk = 4'h0;
      rec = {rec[7:4] & 4'b1010, rec[3:0]};
      chk(busy, 1'b1);
      chk(nv_req, 1'b1);
      waitr(100); // Whole-record store under setting 01 ends well before restart
      rdchk(8'h00, rec);
      $display("track done");
   endtask

   // Every retry delay code
   task automatic t_delay();
      wr(8'h47, 8'h03);
      for (int s = 0; s < 8; s++) begin
         wr(8'h4f, s[7:0]);
         hit_crit();
         waitr(100);
         chk(k, 11 + 2 * s);
      end
      $display("delay done");
   endtask

   // Latch-off with a slow store, released by software then by the pin
   task automatic t_latch();
      wr(8'h47, 8'h00);
      wr(8'h4f, 8'h08);
      dly = 8'd30;
      hit_crit();
      tick(28);
      chk(busy, 1'b1);
      tick(4);
      chk(busy, 1'b0);
      waitr(20); // Store finished before release
      chk(restart, 1'b0);
      chk(gate, 1'b0);
      rdchk(8'h51, 8'h04);
      wr(8'h50, 8'h00);
      rdchk(8'h51, 8'h0c);
      wr(8'h50, 8'hff);
      waitr(10);
      chk(restart, 1'b1);
      rdchk(8'h50, 8'h01);
      hit_crit();
      waitr(40);
      chk(restart, 1'b0);
      chk(busy, 1'b0);
      en_in = 1'b0;
      tick(4);
      chk(gate, 1'b0);
      en_in = 1'b1;
      waitr(10);
      chk(restart, 1'b1);
      $display("latch done");
   endtask

   task automatic summarize();
      $display("checks=%0d mismatches=%0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Store time kept below every retry length except in t_latch
   initial begin
      tick(16);
      rst_in = 1'b0;
      tick(4);
      t_regs();
      t_log();
      t_trk();
      t_delay();
      t_latch();
      summarize();
   end
endmodule
